/* core/common_cmd_status_handler.sv */
`timescale 1ns/1ps
module common_cmd_status_handler #(
  // Identification fields, left-justified, zero-padded; values are arbitrary
  parameter logic [127:0] MakerName = {"ACME LAB", 64'h0},
  parameter logic [127:0] ModelName = {"MODEL-A", 72'h0},
  parameter logic [127:0] SerialName = 128'h0,
  parameter logic [127:0] FirmwareName = 128'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Decoded command strobe
  input wire logic cmdValid,
  input wire cch_pkg::cch_cmd_t cmdCode,
  output logic cmdReady,
  // Event sources, one-cycle pulses
  input wire logic powerOnEvent,
  input wire logic userRequestEvent,
  input wire logic commandErrorFlag,
  input wire logic runFailureEvent,
  input wire logic deviceErrorEvent,
  input wire logic queryErrorFlag,
  // Functional unit activity
  input wire logic opStart,
  input wire logic opFinish,
  // Output queue byte stream
  output logic [7:0] outByte,
  output logic outValid,
  output logic outLast,
  input wire logic outReady,
  // Status byte message-waiting flag, consumer takes each byte
  output logic [7:0] statusByte,
  // Device function reset pulse and idle states
  output logic devReset,
  output logic commandIdleState,
  output logic queryIdleState
);
  typedef enum {
    S_IDLE,
    S_EVENT,
    S_ID,
    S_ACK
  } cch_state_t;

  cch_state_t state_q;
  logic [7:0] event_status_reg_q;
  logic [7:0] captured_q;
  logic [23:0] digits;
  logic [1:0] numDigits;
  logic [1:0] digIdx_q;
  logic [1:0] fieldIdx_q;
  logic [4:0] charIdx_q;
  logic [6:0] sentCnt_q;
  logic waitCmd_q;
  logic waitQry_q;
  logic allIdle;
  logic [7:0] pendingBits;
  logic [127:0] fieldWord;
  logic [7:0] fieldChar;
  logic fieldEnd;
  logic outFire;
  logic lastByte;
  logic eventTake;
  logic opDoneSet;
  logic ackFire;

  // Per-operation bookkeeping lives in the counter module
  cch_pending u_pending (
    .clk(clk),
    .rst_n(rst_n),
    .opStart(opStart),
    .opFinish(opFinish),
    .allIdle(allIdle)
  );

  cch_dec_fmt u_fmt (
    .value(captured_q),
    .digits(digits),
    .numDigits(numDigits)
  );

  // Refuse while the acknowledge launches, so no taken query is lost
  assign cmdReady = (state_q == S_IDLE) && !ackFire;
  assign outFire = outValid && outReady;
  assign eventTake = cmdValid && cmdReady && cmdCode == cch_pkg::CMD_EVENT_Q;
  assign opDoneSet = waitCmd_q && allIdle;
  assign ackFire = waitQry_q && allIdle && state_q == S_IDLE;

  // Event inputs gathered at their weights
  always_comb begin
    pendingBits = 8'h00;
    pendingBits[cch_pkg::PowerOnBit] = powerOnEvent;
    pendingBits[cch_pkg::UserReqBit] = userRequestEvent;
    pendingBits[cch_pkg::CmdErrBit] = commandErrorFlag;
    pendingBits[cch_pkg::RunFailBit] = runFailureEvent;
    pendingBits[cch_pkg::DevErrBit] = deviceErrorEvent;
    pendingBits[cch_pkg::QryErrBit] = queryErrorFlag;
    pendingBits[cch_pkg::OpDoneBit] = opDoneSet;
  end

  // Event register: a new event in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_status_reg_q <= cch_pkg::EventResetVal;
    end else if (eventTake) begin
      event_status_reg_q <= pendingBits & cch_pkg::EventUsedMask;
    end else begin
      // Reset command does not touch this register
      event_status_reg_q <= (event_status_reg_q | pendingBits)
                            & cch_pkg::EventUsedMask;
    end
  end

  // Snapshot for the answer, taken before the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      captured_q <= 8'h00;
    end else if (eventTake) begin
      captured_q <= event_status_reg_q | (pendingBits
                    & cch_pkg::EventUsedMask);
    end
  end

  // Op-complete waits; a reset command returns both to idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitCmd_q <= 1'b0;
      waitQry_q <= 1'b0;
    end else if (cmdValid && cmdReady && cmdCode == cch_pkg::CMD_RESET) begin
      waitCmd_q <= 1'b0;
      waitQry_q <= 1'b0;
    end else begin
      if (cmdValid && cmdReady && cmdCode == cch_pkg::CMD_OPDONE) begin
        waitCmd_q <= 1'b1;
      end else if (opDoneSet) begin
        waitCmd_q <= 1'b0;
      end
      if (cmdValid && cmdReady && cmdCode == cch_pkg::CMD_OPDONE_Q) begin
        waitQry_q <= 1'b1;
      end else if (ackFire) begin
        waitQry_q <= 1'b0;
      end
    end
  end

  assign commandIdleState = !waitCmd_q;
  assign queryIdleState = !waitQry_q;

  // Device function reset pulse; status and queue are left alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      devReset <= 1'b0;
    end else begin
      devReset <= cmdValid && cmdReady
                  && cmdCode == cch_pkg::CMD_RESET;
    end
  end

  // Current identification field and its character
  always_comb begin
    case (fieldIdx_q)
      2'h0: fieldWord = MakerName;
      2'h1: fieldWord = ModelName;
      2'h2: fieldWord = SerialName;
      default: fieldWord = FirmwareName;
    endcase
    fieldChar = fieldWord[8'(127 - 8 * charIdx_q) -: 8];
    // Empty field becomes ASCII zero so every field carries data
    if (charIdx_q == 5'h00 && fieldChar == 8'h00) begin
      fieldChar = cch_pkg::AsciiZero;
    end
    // Illegal bytes are replaced by a blank rather than break the fields
    if (fieldChar != 8'h00 && (fieldChar < cch_pkg::AsciiLow
        || fieldChar > cch_pkg::AsciiHigh || fieldChar == cch_pkg::AsciiComma
        || fieldChar == cch_pkg::AsciiSemi)) begin
      fieldChar = cch_pkg::AsciiLow;
    end
    fieldEnd = fieldChar == 8'h00 || charIdx_q == 5'(cch_pkg::FieldLen);
  end

  // Output byte and last marker
  always_comb begin
    outByte = 8'h00;
    lastByte = 1'b0;
    outValid = 1'b0;
    case (state_q)
      S_EVENT: begin
        outValid = 1'b1;
        outByte = digits[8'(23 - 8 * digIdx_q) -: 8];
        lastByte = (digIdx_q == numDigits - 2'h1);
      end
      S_ID: begin
        outValid = 1'b1;
        outByte = fieldEnd ? cch_pkg::AsciiComma : fieldChar;
        if (fieldEnd && fieldIdx_q == 2'(cch_pkg::NumFields - 1)) begin
          outByte = cch_pkg::AsciiNl;
          lastByte = 1'b1;
        end
        // Hard cap on total length, counted without the terminator
        if (sentCnt_q == 7'(cch_pkg::IdMaxLen)) begin
          outByte = cch_pkg::AsciiNl;
          lastByte = 1'b1;
        end
      end
      S_ACK: begin
        outValid = 1'b1;
        outByte = cch_pkg::AsciiOne;
        lastByte = 1'b1;
      end
      default: begin
        outValid = 1'b0;
      end
    endcase
  end

  assign outLast = lastByte;

  // Message-waiting while any answer byte sits in the queue
  always_comb begin
    statusByte = 8'h00;
    statusByte[cch_pkg::MsgWaitBit] = outValid;
  end

  // Answer sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      digIdx_q <= 2'h0;
      fieldIdx_q <= 2'h0;
      charIdx_q <= 5'h00;
      sentCnt_q <= 7'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          digIdx_q <= 2'h0;
          fieldIdx_q <= 2'h0;
          charIdx_q <= 5'h00;
          sentCnt_q <= 7'h00;
          if (ackFire) begin
            state_q <= S_ACK;
          end else if (eventTake) begin
            state_q <= S_EVENT;
          end else if (cmdValid && cmdCode == cch_pkg::CMD_ID_Q) begin
            state_q <= S_ID;
          end
        end
        S_EVENT: begin
          if (outFire) begin
            digIdx_q <= digIdx_q + 2'h1;
            if (lastByte) begin
              state_q <= S_IDLE;
            end
          end
        end
        S_ID: begin
          if (outFire) begin
            sentCnt_q <= sentCnt_q + 7'h01;
            if (lastByte) begin
              state_q <= S_IDLE;
            end else if (fieldEnd) begin
              fieldIdx_q <= fieldIdx_q + 2'h1;
              charIdx_q <= 5'h00;
            end else begin
              charIdx_q <= charIdx_q + 5'h01;
            end
          end
        end
        S_ACK: begin
          if (outFire) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule : common_cmd_status_handler

/* pkg/cch_pkg.sv */
package cch_pkg;
  // Event status bit positions (weights 128..1)
  localparam int PowerOnBit = 7;
  localparam int UserReqBit = 6;
  localparam int CmdErrBit = 5;
  localparam int RunFailBit = 4;
  localparam int DevErrBit = 3;
  localparam int QryErrBit = 2;
  localparam int OpDoneBit = 0;
  localparam logic [7:0] EventUsedMask = 8'hfd;
  localparam logic [7:0] EventResetVal = 8'h80;
  // Status byte position of the message-waiting flag (weight 16)
  localparam int MsgWaitBit = 4;
  // ASCII constants
  localparam logic [7:0] AsciiZero = 8'h30;
  localparam logic [7:0] AsciiOne = 8'h31;
  localparam logic [7:0] AsciiComma = 8'h2c;
  localparam logic [7:0] AsciiSemi = 8'h3b;
  localparam logic [7:0] AsciiLow = 8'h20;
  localparam logic [7:0] AsciiHigh = 8'h7e;
  localparam logic [7:0] AsciiNl = 8'h0a;
  // Identification string limits
  localparam int IdMaxLen = 72;
  localparam int FieldLen = 16;
  localparam int NumFields = 4;
  // Decimal digit count of an 8-bit value, at most three
  localparam int MaxDigits = 3;

  // Commands decoded upstream
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_EVENT_Q,
    CMD_ID_Q,
    CMD_OPDONE,
    CMD_OPDONE_Q,
    CMD_RESET
  } cch_cmd_t;
endpackage : cch_pkg

/* core/cch_dec_fmt.sv */
`timescale 1ns/1ps
// Converts an 8-bit value into up to three ASCII decimal digits
module cch_dec_fmt (
  // Value in
  input wire logic [7:0] value,
  // Digits out, most significant first
  output logic [23:0] digits,
  output logic [1:0] numDigits
);
  logic [7:0] hund;
  logic [7:0] tens;
  logic [7:0] ones;

  // Plain division; the value is small enough to keep this combinational
  always_comb begin
    hund = value / 8'h64;
    tens = (value / 8'h0a) % 8'h0a;
    ones = value % 8'h0a;
    if (hund != 8'h00) begin
      digits = {cch_pkg::AsciiZero + hund, cch_pkg::AsciiZero + tens,
                cch_pkg::AsciiZero + ones};
      numDigits = 2'h3;
    end else if (tens != 8'h00) begin
      digits = {cch_pkg::AsciiZero + tens, cch_pkg::AsciiZero + ones,
                8'h00};
      numDigits = 2'h2;
    end else begin
      digits = {cch_pkg::AsciiZero + ones, 16'h0000};
      numDigits = 2'h1;
    end
  end
endmodule : cch_dec_fmt

/* core/cch_pending.sv */
`timescale 1ns/1ps
// Counts operations in flight in the functional units
module cch_pending (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Start and finish pulses
  input wire logic opStart,
  input wire logic opFinish,
  // Nothing outstanding
  output logic allIdle
);
  logic [7:0] count_q;

  // Simultaneous start and finish cancel out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= 8'h00;
    end else if (opStart && !opFinish) begin
      count_q <= count_q + 8'h01;
    end else if (opFinish && !opStart && count_q != 8'h00) begin
      count_q <= count_q - 8'h01;
    end
  end

  assign allIdle = (count_q == 8'h00) && !opStart;
endmodule : cch_pending

/* bench/cch_props.sv */
`timescale 1ns/1ps
// Port-level checks of the command and status handler
module cch_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command side
  input wire logic cmdValid,
  input wire cch_pkg::cch_cmd_t cmdCode,
  input wire logic cmdReady,
  // Answer side
  input wire logic [7:0] outByte,
  input wire logic outValid,
  input wire logic outLast,
  input wire logic outReady,
  input wire logic [7:0] statusByte,
  // Reset and idle states
  input wire logic devReset,
  input wire logic commandIdleState,
  input wire logic queryIdleState
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] nOut_q;

  // Bytes accepted so far in the current answer
  always_ff @(posedge clk) begin
    if (!rst_n || (outValid && outReady && outLast)) begin
      nOut_q <= 8'h00;
    end else if (outValid && outReady) begin
      nOut_q <= nOut_q + 8'h01;
    end
  end

  // Command takes and the reset outcome
  sequence evTake;
    cmdValid && cmdReady && cmdCode == cch_pkg::CMD_EVENT_Q;
  endsequence
  sequence rstTake;
    cmdValid && cmdReady && cmdCode == cch_pkg::CMD_RESET;
  endsequence
  sequence rstDone;
    devReset && commandIdleState && queryIdleState ##1 !devReset;
  endsequence

  a_event_answer:
    assert property (evTake |=> outValid && outByte inside {[8'h30:8'h39]})
    else $error("event answer does not start with a digit");
  a_msg_wait_flag:
    assert property (statusByte == {3'h0, outValid, 4'h0})
    else $error("status byte does not follow pending answer");
  a_reset_action:
    assert property (rstTake |=> rstDone)
    else $error("reset command did not pulse and idle");
  a_byte_legal:
    assert property (outValid |-> outByte != 8'h3b &&
      (outByte == 8'h0a || outByte inside {[8'h20:8'h7e]}))
    else $error("answer byte outside printable range");
  a_answer_cap:
    assert property (nOut_q <= 8'h48)
    else $error("answer longer than allowed");
  a_out_hold:
    assert property (outValid && !outReady |=>
      outValid && $stable(outByte) && $stable(outLast))
    else $error("answer byte changed while stalled");
  a_busy_refuse:
    assert property (outValid |-> !cmdReady)
    else $error("command accepted while answer streams");
  a_pulse_once:
    assert property ($rose(devReset) |=> !devReset)
    else $error("device reset longer than one cycle");
endmodule : cch_props

bind common_cmd_status_handler cch_props u_props (.clk, .rst_n,
  .cmdValid, .cmdCode, .cmdReady, .outByte, .outValid, .outLast,
  .outReady, .statusByte, .devReset, .commandIdleState, .queryIdleState);

/* bench/cch_ctl_model.sv */
`timescale 1ns/1ps
// Controller reading the output queue, prompt or stalling
module cch_ctl_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Output queue
  input wire logic [7:0] outByte,
  input wire logic outValid,
  input wire logic outLast,
  output logic outReady,
  // Stall mode
  input wire logic slow
);
  logic [8:0] got [$];

  // Take byte with end mark; slow mode stalls two of three cycles
  always @(posedge clk) begin
    if (rst_n && outValid && outReady) got.push_back({outLast, outByte});
    #1 outReady = rst_n && (!slow || $urandom_range(0, 2) == 0);
  end
endmodule : cch_ctl_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
// Drives commands and events, compares answers with a model
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  cch_pkg::cch_cmd_t cmdCode = cch_pkg::CMD_NONE;
  logic [5:0] evt = 6'h00;
  logic opStart = 1'b0;
  logic opFinish = 1'b0;
  logic slow = 1'b0;
  logic cmdReady, outValid, outLast, outReady, devReset;
  logic commandIdleState, queryIdleState;
  logic [7:0] outByte, statusByte;
  int n_fail = 0;
  int n_checks = 0;
  int evReg = 128;
  int k;

  always #5 clk = ~clk;

  common_cmd_status_handler dut (.clk(clk), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdReady(cmdReady),
    .powerOnEvent(evt[5]), .userRequestEvent(evt[4]),
    .commandErrorFlag(evt[3]), .runFailureEvent(evt[2]),
    .deviceErrorEvent(evt[1]), .queryErrorFlag(evt[0]),
    .opStart(opStart), .opFinish(opFinish), .outByte(outByte),
    .outValid(outValid), .outLast(outLast), .outReady(outReady),
    .statusByte(statusByte), .devReset(devReset),
    .commandIdleState(commandIdleState), .queryIdleState(queryIdleState));
  cch_ctl_model ctl (.clk(clk), .rst_n(rst_n), .outByte(outByte),
    .outValid(outValid), .outLast(outLast), .outReady(outReady),
    .slow(slow));

  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask : check

  task complete_run;
    $display("Counts: %0d checks, %0d failed", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Offer a command, hold it until the edge that takes it
  task send(input cch_pkg::cch_cmd_t c);
    @(posedge clk) #1 cmdValid = 1'b1;
    cmdCode = c;
    while (!cmdReady) @(posedge clk) #1;
    @(posedge clk) #1 cmdValid = 1'b0;
  endtask : send

  // Whole answer with end mark on the final byte only
  task expect_str(input string s);
    int i;
    for (i = 0; i < 800 && ctl.got.size() < s.len(); i++) @(posedge clk);
    #1 check("answer length", s.len(), ctl.got.size());
    for (i = 0; i < s.len() && ctl.got.size() > 0; i++) begin
      check("answer byte", {i == s.len() - 1, s[i]}, ctl.got.pop_front());
    end
    ctl.got.delete();
  endtask : expect_str

  task ev_query;
    send(cch_pkg::CMD_EVENT_Q);
    expect_str($sformatf("%0d", evReg));
    evReg = 0;
  endtask : ev_query

  task pulse(input logic [5:0] m, input logic s, input logic f);
    @(posedge clk) #1 evt = m;
    opStart = s;
    opFinish = f;
    @(posedge clk) #1 evt = 6'h00;
    opStart = 1'b0;
    opFinish = 1'b0;
    evReg = evReg | (int'(m) << 2);
  endtask : pulse

  initial begin
    void'($urandom(63));
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    ev_query();
    ev_query();
    // Each source alone, then random mixes, with stalls switched at random on every pass
    for (k = 0; k < 10; k++) begin
      pulse(k < 6 ? 6'h01 << k : 6'($urandom), 1'b0, 1'b0);
      slow = 1'($urandom);
      ev_query();
    end
    // Op-complete command waits for the functional unit
    pulse(6'h08, 1'b1, 1'b0);
    send(cch_pkg::CMD_OPDONE);
    repeat (4) @(posedge clk);
    #1 check("cmd idle while pending", 0, commandIdleState);
    pulse(6'h00, 1'b0, 1'b1);
    evReg = evReg | 1;
    repeat (2) @(posedge clk);
    ev_query();
    // Op-complete query waits, then queues one byte
    pulse(6'h00, 1'b1, 1'b0);
    send(cch_pkg::CMD_OPDONE_Q);
    repeat (5) @(posedge clk);
    #1 check("early ack", 0, ctl.got.size());
    check("status early", 8'h00, statusByte);
    pulse(6'h00, 1'b0, 1'b1);
    expect_str("1");
    // Reset drops the wait but keeps the event register
    pulse(6'h08, 1'b1, 1'b0);
    send(cch_pkg::CMD_OPDONE);
    send(cch_pkg::CMD_RESET);
    check("reset pulse", 1, devReset);
    @(posedge clk) #1 check("idle after reset", 1, commandIdleState);
    check("query idle", 1, queryIdleState);
    pulse(6'h00, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    ev_query();
    // Identification asked last, answer read with stalls
    slow = 1'b1;
    send(cch_pkg::CMD_ID_Q);
    expect_str("ACME LAB,MODEL-A,0,0\n");
    complete_run();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule : tb_top
